/* File: rtl/tss_consts.svh */
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
// Clock rate and hold-off timing
`define TSS_CLK_HZ 100000000
`define TSS_HOLD_OFF_MS 1000
`define TSS_HOLD_OFF_CYC ((`TSS_CLK_HZ / 1000) * `TSS_HOLD_OFF_MS)
// Transmit dominant timeout, long variant only
`define TSS_TXDOM_LONG_US 4000
`define TSS_TXDOM_CYC ((`TSS_CLK_HZ / 1000000) * `TSS_TXDOM_LONG_US)
// Nominal thresholds in degrees C, fixed by the comparators
`define TSS_LEVEL_ONE_DEGC 155
`define TSS_LEVEL_TWO_DEGC 175
`endif

/* File: rtl/tss_pkg.sv */
`default_nettype none
package tss_pkg;
  typedef enum logic [2:0] {
    TSS_ST_RUN = 3'h1,
    TSS_ST_OFF = 3'h2,
    TSS_ST_HOLD = 3'h4
  } tss_state_t;
endpackage
`default_nettype wire

/* File: rtl/tss_thermal_shutdown_sequencer.sv */
`include "tss_consts.svh"
`default_nettype none
module tss_thermal_shutdown_sequencer #(
  parameter int unsigned HOLD_OFF_CYC = `TSS_HOLD_OFF_CYC,
  parameter int unsigned TXDOM_CYC = `TSS_TXDOM_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Comparator levels
  input wire logic thermal_level_one_i,
  input wire logic thermal_level_two_i,
  input wire logic thermal_level_one_release_i,
  // Application pins
  input wire logic high_side_driver_en_i,
  input wire logic can_en_i,
  input wire logic txd_i,
  // Controls
  output logic main_regulator_en_o,
  output logic high_side_driver_on_o,
  output logic thermal_diag_n_o,
  output logic can_active_o,
  output logic can_txd_o,
  output logic thermal_reset_o,
  output logic watchdog_timeout_mode_o,
  output tss_pkg::tss_state_t state_o
);
  import tss_pkg::*;

  // Last count of each timer, sized to the counters
  localparam logic [31:0] HOLD_LAST = 32'(HOLD_OFF_CYC - 1);
  localparam logic [31:0] DOM_LAST = 32'(TXDOM_CYC - 1);

  // Sequencer state
  tss_state_t state_q;
  tss_state_t state_d;
  logic run_next;

  // Hold-off timing after a level two trip
  logic [31:0] hold_cnt_q;
  logic hold_done;

  // High-side over-temperature latch
  logic hs_block_q;
  logic level_hot;
  logic cooled;

  // Transmit dominant timing
  logic [31:0] dom_cnt_q;
  logic dom_block_q;
  logic dom_expired;

  // Off history for the watchdog mode
  logic off_prev_q;

  // Hold-off time reached
  assign hold_done = (hold_cnt_q >= HOLD_LAST);

  // Either comparator reports heat
  assign level_hot = thermal_level_one_i || thermal_level_two_i;

  // Both comparators quiet, below level one
  assign cooled = !level_hot;

  // Sequencer heads for normal operation
  assign run_next = (state_d == TSS_ST_RUN);

  // Long dominant limit reached
  assign dom_expired = (dom_cnt_q >= DOM_LAST);

  // Device state transitions
  always_comb begin
    state_d = state_q;
    case (state_q)
      // Normal operation, watch for level two
      TSS_ST_RUN: begin
        if (thermal_level_two_i) begin
          state_d = TSS_ST_OFF;
        end
      end
      // Everything off until below level one
      TSS_ST_OFF: begin
        if (cooled) begin
          state_d = TSS_ST_HOLD;
        end
      end
      // Cooling wait, any heat rearms the shutdown
      TSS_ST_HOLD: begin
        if (level_hot) begin
          state_d = TSS_ST_OFF;
        end else if (hold_done) begin
          state_d = TSS_ST_RUN;
        end
      end
      // Unknown code falls back to safe off
      default: state_d = TSS_ST_OFF;
    endcase
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= TSS_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Hold-off counter, runs only while cooled in hold state
  always_ff @(posedge core_clk_i) begin
    if (srst_i || state_d != TSS_ST_HOLD || state_q != TSS_ST_HOLD) begin
      hold_cnt_q <= 32'h0;
    end else if (!hold_done) begin
      hold_cnt_q <= hold_cnt_q + 32'h1;
    end
  end

  // High-side block with hysteresis
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hs_block_q <= 1'b0;
    end else if (level_hot) begin
      hs_block_q <= 1'b1;
    end else if (!thermal_level_one_release_i) begin
      hs_block_q <= 1'b0;
    end
  end

  // Dominant time counter, cleared by recessive data or idle transceiver
  always_ff @(posedge core_clk_i) begin
    if (srst_i || txd_i || !can_active_o) begin
      dom_cnt_q <= 32'h0;
    end else if (!dom_expired) begin
      dom_cnt_q <= dom_cnt_q + 32'h1;
    end
  end

  // Transmit block, released when data returns recessive or the transceiver goes idle
  always_ff @(posedge core_clk_i) begin
    if (srst_i || txd_i || !can_active_o) begin
      dom_block_q <= 1'b0;
    end else if (dom_expired) begin
      dom_block_q <= 1'b1;
    end
  end

  // Main regulator follows the next state, off outside run
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      main_regulator_en_o <= 1'b1;
    end else begin
      main_regulator_en_o <= run_next;
    end
  end

  // High-side driver, gated by state, latch and level one
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      high_side_driver_on_o <= 1'b0;
    end else begin
      high_side_driver_on_o <= run_next && !hs_block_q &&
        !thermal_level_one_i && high_side_driver_en_i;
    end
  end

  // Diagnostic low while an enabled driver is held off by heat
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      thermal_diag_n_o <= 1'b1;
    end else begin
      thermal_diag_n_o <= !(high_side_driver_en_i &&
        (hs_block_q || thermal_level_one_i));
    end
  end

  // Off flag one cycle back
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      off_prev_q <= 1'b0;
    end else begin
      off_prev_q <= (state_q != TSS_ST_RUN);
    end
  end

  // Reset towards the controller while off or holding
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      thermal_reset_o <= 1'b0;
    end else begin
      thermal_reset_o <= (state_q != TSS_ST_RUN);
    end
  end

  // Watchdog restarts in timeout mode, kept one cycle past recovery
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      watchdog_timeout_mode_o <= 1'b1;
    end else begin
      watchdog_timeout_mode_o <= (state_q != TSS_ST_RUN) ||
        off_prev_q;
    end
  end

  // CAN transceiver alive at level one, dead at level two
  always_comb begin
    can_active_o = (state_q == TSS_ST_RUN) && can_en_i;
  end

  // Transmit data forced recessive on timeout or idle transceiver
  always_comb begin
    can_txd_o = txd_i || dom_block_q || !can_active_o;
  end

  // State seen from outside
  assign state_o = state_q;
endmodule
`default_nettype wire

/* File: bench/tss_props.sv */
`default_nettype none
module tss_props (
  input wire logic core_clk_i, srst_i, txd_i, can_txd_o, thermal_reset_o,
    thermal_level_one_i, thermal_level_two_i, thermal_level_one_release_i,
    main_regulator_en_o, high_side_driver_on_o, watchdog_timeout_mode_o,
  input wire tss_pkg::tss_state_t state_o
);
  timeunit 1ns / 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  AST_TWO: assert property (thermal_level_two_i
    |=> state_o[1] && !main_regulator_en_o) else $error("not off");
  AST_ONE: assert property (thermal_level_one_i
    |=> !high_side_driver_on_o) else $error("hs on");
  AST_REL: assert property ($rose(high_side_driver_on_o)
    |-> !$past(thermal_level_one_release_i)) else $error("hs early");
  AST_HOLD: assert property ($rose(state_o[0])
    |-> $past(state_o[2], 15)) else $error("hold short");
  AST_RARM: assert property (state_o[2] && thermal_level_one_i
    |=> state_o[1]) else $error("no rearm");
  AST_RST: assert property (state_o[1] |=> thermal_reset_o)
    else $error("no reset");
  AST_WD: assert property ($fell(thermal_reset_o)
    |-> watchdog_timeout_mode_o) else $error("wd mode");
  AST_TX: assert property (!can_txd_o |-> !txd_i)
    else $error("txd");
endmodule
bind tss_thermal_shutdown_sequencer tss_props props_u (
  .core_clk_i(core_clk_i),
  .srst_i(srst_i),
  .txd_i(txd_i),
  .can_txd_o(can_txd_o),
  .thermal_reset_o(thermal_reset_o),
  .thermal_level_one_i(thermal_level_one_i),
  .thermal_level_two_i(thermal_level_two_i),
  .thermal_level_one_release_i(thermal_level_one_release_i),
  .main_regulator_en_o(main_regulator_en_o),
  .high_side_driver_on_o(high_side_driver_on_o),
  .watchdog_timeout_mode_o(watchdog_timeout_mode_o),
  .state_o(state_o)
);
`default_nettype wire

/* File: bench/tss_mcu_model.sv */
`default_nettype none
// Controller pins, moved on the falling edge; data idles recessive
module tss_mcu_model (
  input wire logic core_clk_i,
  input wire logic tx_req,
  output logic high_side_driver_en_i = 1'h0,
  output logic txd_i
);
  timeunit 1ns / 1ps;
  // Driver enable raised once the clock runs
  always @(negedge core_clk_i) begin
    high_side_driver_en_i <= 1'h1;
  end
  // Data pin follows the request without a race on the same edge
  always_comb begin
    txd_i = tx_req;
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns / 1ps;
  logic core_clk_i = 1'h0, srst_i = 1'h1, can_en_i = 1'h1, tx_req = 1'h1;
  logic thermal_level_one_i = 1'h0, thermal_level_two_i = 1'h0;
  logic thermal_level_one_release_i = 1'h0, high_side_driver_en_i, txd_i;
  logic main_regulator_en_o, high_side_driver_on_o, can_txd_o;
  logic thermal_diag_n_o, can_active_o;
  logic [31:0] seed = 32'h4f021a46;
  logic [7:0] q[$];
  int errors = 0, checks_done = 0;
  tss_pkg::tss_state_t state_o;
  tss_mcu_model mcu_u (.*);
  tss_thermal_shutdown_sequencer #(.HOLD_OFF_CYC(20), .TXDOM_CYC(10)) dut_u
    (.*, .thermal_reset_o(), .watchdog_timeout_mode_o());
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_outputs(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t outputs differ", $time);
    end
  endtask
  task automatic step(input logic [3:0] v, input int n, input logic [7:0] e);
    {tx_req, thermal_level_two_i, thermal_level_one_i,
      thermal_level_one_release_i} = v;
    repeat (n) @(negedge core_clk_i);
    q.push_back(e);
    @(negedge core_clk_i);
  endtask
  initial forever #5 core_clk_i = ~core_clk_i;
  // Oldest note against diag, CAN, regulator, driver, txd and state
  always @(posedge core_clk_i) if (q.size() > 0) begin
    cmp_outputs({thermal_diag_n_o, can_active_o, main_regulator_en_o,
      high_side_driver_on_o, can_txd_o, state_o}, q.pop_front());
  end
  // Random traffic, then the thermal sequence
  initial begin
    repeat (12) @(negedge core_clk_i);
    srst_i = 1'h0;
    repeat (40) begin
      @(negedge core_clk_i) seed = xs(seed);
      tx_req = seed[0];
    end
    step(4'hb, 3, 8'h69);
    step(4'h9, 3, 8'h69);
    step(4'h8, 3, 8'hf9);
    step(4'hf, 3, 8'h0a);
    step(4'hb, 30, 8'h0a);
    step(4'h8, 5, 8'h8c);
    step(4'hb, 2, 8'h0a);
    step(4'h8, 30, 8'hf9);
    step(4'h0, 3, 8'hf1);
    step(4'h0, 15, 8'hf9);
    finish_test();
  end
endmodule
`default_nettype wire
